// file: bench/wcm_chk_sva.sv
`include "wcm_defines.vh"

module wcm_chk_sva (
    input wire CLK,
    input wire RST,
    input wire HSEL,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire HREADY,
    input wire HREADYOUT,
    input wire HRESP,
    input wire CPU_RUN,
    input wire CPU_CLK_EN,
    input wire SUB_CLK_EN,
    input wire OSC_OVERSHOOT,
    input wire MAIN_CLK_FAST,
    input wire SUB_CLK_FAST
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    // --------------------------------------------------------------------
    // Run lengths, held after each run so a mask end can be judged later
    // --------------------------------------------------------------------
    logic [9:0] ovs_n_ff;
    logic [9:0] fast_n_ff;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ovs_n_ff <= 10'h000;
            fast_n_ff <= 10'h000;
        end else begin
            if ($rose(OSC_OVERSHOOT))
                ovs_n_ff <= 10'h001;
            else if (OSC_OVERSHOOT)
                ovs_n_ff <= ovs_n_ff + 10'h001;
            if ($rose(MAIN_CLK_FAST))
                fast_n_ff <= 10'h001;
            else if (MAIN_CLK_FAST)
                fast_n_ff <= fast_n_ff + 10'h001;
        end
    end

    // --------------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------------
    a_hresp_okay: assert property (HRESP == 1'b0)
        else $error("bus response not okay");
    a_write_nowait: assert property (HSEL && HREADY && HTRANS == `WCM_HTRANS_NONSEQ && HWRITE
        && HSIZE == `WCM_HSIZE_WORD |=> HREADYOUT) else $error("write data phase stalled");
    a_read_wait: assert property (HSEL && HREADY && HTRANS == `WCM_HTRANS_NONSEQ && !HWRITE
        && HSIZE == `WCM_HSIZE_WORD |=> !HREADYOUT ##1 HREADYOUT) else $error("read wait state wrong");
    a_ovs_len: assert property ($fell(OSC_OVERSHOOT) |-> ovs_n_ff == 10'h2ee)
        else $error("overshoot window length wrong");
    a_mask_span: assert property ($rose(CPU_RUN) |-> (ovs_n_ff >= 10'h0f7 && ovs_n_ff <= 10'h0fd)
        || (ovs_n_ff >= 10'h2eb && ovs_n_ff <= 10'h2f1)) else $error("execution mask length wrong");
    a_short_fast: assert property ($rose(CPU_RUN) && OSC_OVERSHOOT && ovs_n_ff < 10'h200
        |-> ##[0:2] MAIN_CLK_FAST) else $error("short mask without fast main clock");
    a_fast_cause: assert property ($rose(MAIN_CLK_FAST) |-> ##[0:1] CPU_RUN)
        else $error("fast main clock outside run");
    a_fast_len: assert property ($fell(MAIN_CLK_FAST) |-> fast_n_ff == 10'h1f4)
        else $error("fast main clock span wrong");
    a_sub_fast: assert property (SUB_CLK_FAST |-> SUB_CLK_EN && (OSC_OVERSHOOT || $past(OSC_OVERSHOOT)))
        else $error("sub clock fast without overshoot");
    a_run_gate: assert property (!CPU_RUN && !$past(CPU_RUN) |-> !CPU_CLK_EN)
        else $error("cpu clock enabled while held off");
endmodule

// file: bench/wcm_fw_model.sv
`include "wcm_defines.vh"

module wcm_fw_model (
    input wire logic clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
    end

    // --------------------------------------------------------------------
    // Single word transfer; ready and read data are taken at the rising edge
    // --------------------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= `WCM_HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= `WCM_HSIZE_WORD;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
        // Released data lines must not keep looking valid.
        hwdata <= ~d;
    endtask
endmodule

// file: bench/wcm_top_test.sv
`include "wcm_defines.vh"

module wcm_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wake = 1'b0;
    logic supv_ev = 1'b0;
    logic power_up_clear_reset = 1'b0;
    wire hsel, hwrite, hreadyout, hresp, cpu_run, cpu_clk_en, sub_clk_en;
    wire osc_ovs, main_fast, sub_fast, irq;
    wire [1:0] htrans;
    wire [2:0] hsize;
    wire [31:0] haddr, hwdata, hrdata;
    int err_total = 0;
    int checks_done = 0;
    int seed = 86;

    always #4 clk = ~clk;

    wcm_top u_wcm_top (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRDATA(hrdata),
        .HRESP(hresp), .WAKE(wake), .SUPV_EVENT(supv_ev), .PUC_REQ(power_up_clear_reset), .CPU_RUN(cpu_run),
        .CPU_CLK_EN(cpu_clk_en), .SUB_CLK_EN(sub_clk_en), .OSC_OVERSHOOT(osc_ovs),
        .MAIN_CLK_FAST(main_fast), .SUB_CLK_FAST(sub_fast), .IRQ(irq));
    wcm_fw_model u_wcm_fw_model (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // --------------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_wcm_fw_model.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        u_wcm_fw_model.xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic pulse(input int k);
        if (k == 0)
            wake <= 1'b1;
        else if (k == 1)
            supv_ev <= 1'b1;
        else
            power_up_clear_reset <= 1'b1;
        repeat (2) @(posedge clk);
        wake <= 1'b0;
        supv_ev <= 1'b0;
        power_up_clear_reset <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    function automatic logic [7:0] thr(input logic [1:0] l);
        case (l)
            2'h0: return `WCM_THR_L0;
            2'h1: return `WCM_THR_L1;
            2'h2: return `WCM_THR_L2;
            default: return `WCM_THR_L3;
        endcase
    endfunction
    function automatic logic short_exp(input logic [31:0] c, input logic [3:0] sv);
        return (sv[1:0] == 2'h0 || sv[3:2] == 2'h3) && c[0] && c[15:8] > thr(c[4:3]);
    endfunction
    function automatic int wait_cyc(input logic [1:0] l);
        case (l)
            2'h0: return 32;
            2'h1: return 48;
            2'h2: return 80;
            default: return 100;
        endcase
    endfunction

    // --------------------------------------------------------------------
    // One sleep and wake round
    // --------------------------------------------------------------------
    task automatic sleep_wake(input logic [31:0] c, input logic [3:0] sv, input logic [2:0] code);
        logic [31:0] q;
        int n;
        int lo;
        logic s;
        s = short_exp(c, sv);
        lo = s ? 250 : 750;
        wr(`WCM_A_CTRL, c);
        wr(`WCM_A_SUPV, {28'h0, sv});
        wr(`WCM_A_CLKDIV, 32'h1);
        wr(`WCM_A_SLEEP, {29'h0, code});
        repeat (3) @(posedge clk);
        chk_bit(cpu_run, 1'b0);
        chk_bit(sub_clk_en, code == 3'h3 && c[2]);
        pulse(0);
        repeat (50) @(posedge clk);
        n = 60;
        chk_bit(osc_ovs, 1'b1);
        chk_bit(sub_fast, !c[1]);
        chk_bit(cpu_run, 1'b0);
        while (cpu_run !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        chk_bit(n >= lo && n <= lo + 12, 1'b1);
        repeat (3) @(posedge clk);
        chk_bit(main_fast, s);
        rd(`WCM_A_IRQ_STAT, q);
        chk_bit(q[0], 1'b1);
        chk_bit(irq, 1'b1);
        wr(`WCM_A_IRQ_STAT, 32'h7);
        repeat (2) @(posedge clk);
        chk_bit(irq, 1'b0);
        repeat (2 * wait_cyc(c[4:3])) @(posedge clk);
        wr(`WCM_A_CLKDIV, 32'h0);
        repeat (800) @(posedge clk);
        chk_bit(osc_ovs, 1'b0);
        chk_bit(main_fast, 1'b0);
    endtask

    task tally_and_finish;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        tally_and_finish;
    end

    // --------------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------------
    initial begin
        logic [7:0] ra [5] = '{`WCM_A_CTRL, `WCM_A_SUPV, `WCM_A_CLKDIV, `WCM_A_IRQ_MASK, 8'h1c};
        logic [31:0] rv [5] = '{32'h0105, 32'h3, 32'h0, 32'h0, 32'h0};
        logic [31:0] q;
        logic [31:0] r;
        logic [7:0] f;
        logic [3:0] sv;
        int n;
        int e;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            rd(ra[i], q);
            chk_word(q, rv[i]);
        end
        repeat (4) begin
            r = $random(seed);
            wr(`WCM_A_CLKDIV, {29'h0, r[2:0]});
            rd(`WCM_A_CLKDIV, q);
            e = (r[2:0] > 3'h5) ? 5 : r[2:0];
            chk_word(q, e);
            n = 0;
            repeat (64) begin
                @(negedge clk);
                n += cpu_clk_en;
            end
            @(posedge clk);
            chk_word(n, 64 >> e);
        end
        wr(`WCM_A_SUPV, 32'h0);
        pulse(2);
        rd(`WCM_A_SUPV, q);
        chk_word(q, 32'h3);
        pulse(1);
        rd(`WCM_A_IRQ_STAT, q);
        chk_word(q & 32'h8, 32'h0);
        wr(`WCM_A_SUPV, 32'h3);
        pulse(1);
        rd(`WCM_A_IRQ_STAT, q);
        chk_word(q & 32'h8, 32'h8);
        chk_bit(irq, 1'b0);
        wr(`WCM_A_IRQ_MASK, 32'h8);
        repeat (2) @(posedge clk);
        chk_bit(irq, 1'b1);
        wr(`WCM_A_IRQ_STAT, 32'h8);
        repeat (2) @(posedge clk);
        chk_bit(irq, 1'b0);
        wr(`WCM_A_IRQ_MASK, 32'h1);
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            sv = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : r[2] ? 4'h3 : (r[1] ? 4'hf : 4'h0);
            f = thr(i[1:0]) + ((i == 0) ? 8'h1 : (i == 1) ? 8'h0 : {7'h0, r[0]});
            sleep_wake({16'h0, f, 3'h0, i[1:0], r[4], r[3], i != 7}, sv, r[5] ? 3'h4 : 3'h3);
        end
        tally_and_finish;
    end
endmodule

bind wcm_top wcm_chk_sva u_wcm_chk_sva (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CPU_RUN(CPU_RUN),
    .CPU_CLK_EN(CPU_CLK_EN), .SUB_CLK_EN(SUB_CLK_EN), .OSC_OVERSHOOT(OSC_OVERSHOOT),
    .MAIN_CLK_FAST(MAIN_CLK_FAST), .SUB_CLK_FAST(SUB_CLK_FAST));

// file: hdl/wcm_ahb_slave.v
`include "wcm_defines.vh"

module wcm_ahb_slave (
    input wire clk,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] rd_data,
    output wire [`WCM_ADDR_W-1:0] reg_addr,
    output wire wr_en,
    output reg hreadyout,
    output reg [31:0] hrdata
);

    reg [`WCM_ADDR_W-1:0] addr_ff;
    reg wr_pend_ff;
    reg rd_pend_ff;
    wire take;

    assign take = hsel && hready && (htrans == `WCM_HTRANS_NONSEQ) && (hsize == `WCM_HSIZE_WORD);
    assign reg_addr = addr_ff;
    assign wr_en = wr_pend_ff;

    // Reads take one wait state so that a write in the previous data phase is already visible.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_ff <= {`WCM_ADDR_W{1'b0}};
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= 32'h0;
        end else if (rd_pend_ff) begin
            rd_pend_ff <= 1'b0;
            hrdata <= rd_data;
            hreadyout <= 1'b1;
        end else begin
            wr_pend_ff <= take && hwrite;
            rd_pend_ff <= take && !hwrite;
            hreadyout <= !(take && !hwrite);
            if (take) begin
                addr_ff <= haddr[`WCM_ADDR_W-1:0];
            end
        end
    end

endmodule

// file: hdl/wcm_defines.vh
`ifndef WCM_DEFINES_VH
`define WCM_DEFINES_VH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
// Counts of 8 ns cycles for 6 us, 2 us and 4 us.
`define WCM_OVS_CYC 12'h2ee
`define WCM_SHORT_CYC 12'h0fa
`define WCM_FAST_CYC 12'h1f4
`define WCM_CNT_W 12

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define WCM_ADDR_W 8
`define WCM_A_CTRL 8'h00
`define WCM_A_SUPV 8'h04
`define WCM_A_CLKDIV 8'h08
`define WCM_A_SLEEP 8'h0c
`define WCM_A_STATUS 8'h10
`define WCM_A_IRQ_STAT 8'h14
`define WCM_A_IRQ_MASK 8'h18

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define WCM_CTRL_MAIN_OSC 0
`define WCM_CTRL_SUB_XTAL 1
`define WCM_CTRL_SUB_REQ 2
`define WCM_CTRL_LVL 4:3
`define WCM_CTRL_FREQ 15:8
`define WCM_CTRL_RST 16'h0105
`define WCM_SUPV_RST 4'h3
`define WCM_SUPV_LSE 0
`define WCM_SUPV_LME 1
`define WCM_SUPV_LSFP 2
`define WCM_SUPV_LMFP 3
`define WCM_DIV_RST 3'h0
`define WCM_DIV_MAX 3'h5
`define WCM_SLEEP_L3 3'h3
`define WCM_SLEEP_L4 3'h4
`define WCM_IRQ_W 4
`define WCM_IRQ_WAKE 0
`define WCM_IRQ_MASK_END 1
`define WCM_IRQ_OVS_END 2
`define WCM_IRQ_SUPV 3

// ----------------------------------------------------------------------------
// Oscillator thresholds per core level, in MHz
// ----------------------------------------------------------------------------
`define WCM_THR_L0 8'h04
`define WCM_THR_L1 8'h07
`define WCM_THR_L2 8'h0b
`define WCM_THR_L3 8'h0e

// ----------------------------------------------------------------------------
// AHB-Lite encodings
// ----------------------------------------------------------------------------
`define WCM_HTRANS_NONSEQ 2'h2
`define WCM_HSIZE_WORD 3'h2

`endif

// file: hdl/wcm_sync3.v
module wcm_sync3 #(
    parameter W = 1
) (
    input wire clk,
    input wire rst,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);

    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;
    integer i;

    // The first stage feeds only the second; the output moves once stages two and three agree.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_ff <= {W{1'b0}};
            s2_ff <= {W{1'b0}};
            s3_ff <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    dout[i] <= s3_ff[i];
                end
            end
        end
    end

endmodule

// file: hdl/wcm_top.v
// Overview of operation
// - After power-up-clear with supervisor off, supervisor flags stay dead until SUPV written.
// - Oscillator runs fast for up to 6 us after leaving deep sleep.
// - Normal-performance supervisor and monitor mask CPU execution across the overshoot.
// - Both disabled or full-performance, oscillator main clock above threshold: mask only 2 us.
// - Under the short mask, main clock is flagged fast for 4 us after mask.
// - Peripheral sub-clock from the oscillator is never masked and sees the overshoot.
//
// Chosen here: register access over AHB-Lite and the register offsets.
`include "wcm_defines.vh"

module wcm_top (
    input wire CLK,
    input wire RST,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output wire HREADYOUT,
    output wire [31:0] HRDATA,
    output reg HRESP,
    input wire WAKE,
    input wire SUPV_EVENT,
    input wire PUC_REQ,
    output reg CPU_RUN,
    output reg CPU_CLK_EN,
    output reg SUB_CLK_EN,
    output reg OSC_OVERSHOOT,
    output reg MAIN_CLK_FAST,
    output reg SUB_CLK_FAST,
    output reg IRQ
);

    // ------------------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------------------
    localparam [`WCM_CNT_W-1:0] OVS_CYC = `WCM_OVS_CYC;
    localparam [`WCM_CNT_W-1:0] SHORT_CYC = `WCM_SHORT_CYC;
    localparam [`WCM_CNT_W-1:0] FAST_CYC = `WCM_FAST_CYC;
    localparam [`WCM_CNT_W-1:0] ONE = 12'h001;

    localparam [1:0] ST_RUN = 2'h0;
    localparam [1:0] ST_SLEEP = 2'h1;
    localparam [1:0] ST_MASK = 2'h2;

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    function [7:0] freq_threshold;
        input [1:0] lvl;
        begin
            case (lvl)
                2'h0: freq_threshold = `WCM_THR_L0;
                2'h1: freq_threshold = `WCM_THR_L1;
                2'h2: freq_threshold = `WCM_THR_L2;
                default: freq_threshold = `WCM_THR_L3;
            endcase
        end
    endfunction

    function [`WCM_CNT_W-1:0] count_down;
        input [`WCM_CNT_W-1:0] c;
        begin
            count_down = (c == {`WCM_CNT_W{1'b0}}) ? c : c - ONE;
        end
    endfunction

    // ------------------------------------------------------------------------
    // Bus slave and synchronisers
    // ------------------------------------------------------------------------
    wire [`WCM_ADDR_W-1:0] reg_addr;
    wire wr_en;
    reg [31:0] rd_data;
    wire [2:0] pins_sync;
    reg [2:0] pins_prev_ff;

    wcm_ahb_slave u_slave (
        .clk(CLK),
        .rst(RST),
        .hsel(HSEL),
        .haddr(HADDR),
        .htrans(HTRANS),
        .hwrite(HWRITE),
        .hsize(HSIZE),
        .hready(HREADY),
        .rd_data(rd_data),
        .reg_addr(reg_addr),
        .wr_en(wr_en),
        .hreadyout(HREADYOUT),
        .hrdata(HRDATA)
    );

    wcm_sync3 #(.W(3)) u_sync (
        .clk(CLK),
        .rst(RST),
        .din({PUC_REQ, SUPV_EVENT, WAKE}),
        .dout(pins_sync)
    );

    wire wake_rise = pins_sync[0] && !pins_prev_ff[0];
    wire supv_rise = pins_sync[1] && !pins_prev_ff[1];
    wire puc_rise = pins_sync[2] && !pins_prev_ff[2];

    // ------------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------------
    reg [15:0] ctrl_ff;
    reg [3:0] supv_ff;
    reg [2:0] div_ff;
    reg [2:0] sleep_lvl_ff;
    reg [`WCM_IRQ_W-1:0] irq_stat_ff;
    reg [`WCM_IRQ_W-1:0] irq_mask_ff;
    reg flags_en_ff;
    reg [1:0] state_ff;
    reg short_ff;
    reg [`WCM_CNT_W-1:0] mask_cnt_ff;
    reg [`WCM_CNT_W-1:0] ovs_cnt_ff;
    reg [`WCM_CNT_W-1:0] fast_cnt_ff;
    reg [5:0] div_cnt_ff;

    reg [1:0] nxt_state;
    reg [`WCM_CNT_W-1:0] nxt_mask_cnt;
    reg [`WCM_CNT_W-1:0] nxt_ovs_cnt;
    reg [`WCM_CNT_W-1:0] nxt_fast_cnt;
    reg nxt_short;
    reg [`WCM_IRQ_W-1:0] nxt_irq_stat;
    reg [`WCM_IRQ_W-1:0] irq_set;

    wire lse = supv_ff[`WCM_SUPV_LSE];
    wire lme = supv_ff[`WCM_SUPV_LME];
    wire both_off = !lse && !lme;
    wire both_fp = supv_ff[`WCM_SUPV_LSFP] && supv_ff[`WCM_SUPV_LMFP];
    wire main_osc = ctrl_ff[`WCM_CTRL_MAIN_OSC];
    wire over_thr = ctrl_ff[`WCM_CTRL_FREQ] > freq_threshold(ctrl_ff[`WCM_CTRL_LVL]);
    // The shortened mask only arises with the oscillator driving the main clock above the level's threshold.
    wire short_cond = (both_off || both_fp) && main_osc && over_thr;
    wire wr_sleep = wr_en && (reg_addr == `WCM_A_SLEEP);
    wire sleep_req = wr_sleep && ((HWDATA[2:0] == `WCM_SLEEP_L3) || (HWDATA[2:0] == `WCM_SLEEP_L4));
    wire sub_on_osc = !ctrl_ff[`WCM_CTRL_SUB_XTAL];
    wire sub_alive = (state_ff != ST_SLEEP) ||
        (ctrl_ff[`WCM_CTRL_SUB_REQ] && (sleep_lvl_ff == `WCM_SLEEP_L3));

    // ------------------------------------------------------------------------
    // Wake sequencing
    // ------------------------------------------------------------------------
    always @* begin
        nxt_state = state_ff;
        nxt_mask_cnt = count_down(mask_cnt_ff);
        nxt_ovs_cnt = count_down(ovs_cnt_ff);
        nxt_fast_cnt = count_down(fast_cnt_ff);
        nxt_short = short_ff;
        irq_set = {`WCM_IRQ_W{1'b0}};
        if ((ovs_cnt_ff == ONE)) begin
            irq_set[`WCM_IRQ_OVS_END] = 1'b1;
        end
        case (state_ff)
            ST_RUN: begin
                if (sleep_req) begin
                    nxt_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_rise) begin
                    nxt_state = ST_MASK;
                    nxt_short = short_cond;
                    // The oscillator overshoots on every exit, whatever the supervisor setting.
                    nxt_ovs_cnt = OVS_CYC;
                    // Normal performance masks the whole overshoot; the short case only 2 us.
                    nxt_mask_cnt = short_cond ? SHORT_CYC : OVS_CYC;
                    irq_set[`WCM_IRQ_WAKE] = 1'b1;
                end
            end
            ST_MASK: begin
                if (mask_cnt_ff <= ONE) begin
                    nxt_state = ST_RUN;
                    irq_set[`WCM_IRQ_MASK_END] = 1'b1;
                    if (short_ff) begin
                        nxt_fast_cnt = FAST_CYC;
                    end
                end
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
        if (supv_rise && flags_en_ff) begin
            irq_set[`WCM_IRQ_SUPV] = 1'b1;
        end
        nxt_irq_stat = irq_stat_ff | irq_set;
        if (wr_en && (reg_addr == `WCM_A_IRQ_STAT)) begin
            // A clear never swallows an event arriving in the same cycle.
            nxt_irq_stat = (irq_stat_ff & ~HWDATA[`WCM_IRQ_W-1:0]) | irq_set;
        end
    end

    // ------------------------------------------------------------------------
    // Sequential state and registers
    // ------------------------------------------------------------------------
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            pins_prev_ff <= 3'h0;
            ctrl_ff <= `WCM_CTRL_RST;
            supv_ff <= `WCM_SUPV_RST;
            div_ff <= `WCM_DIV_RST;
            sleep_lvl_ff <= 3'h0;
            irq_stat_ff <= {`WCM_IRQ_W{1'b0}};
            irq_mask_ff <= {`WCM_IRQ_W{1'b0}};
            flags_en_ff <= 1'b1;
            state_ff <= ST_RUN;
            short_ff <= 1'b0;
            mask_cnt_ff <= {`WCM_CNT_W{1'b0}};
            ovs_cnt_ff <= {`WCM_CNT_W{1'b0}};
            fast_cnt_ff <= {`WCM_CNT_W{1'b0}};
        end else begin
            pins_prev_ff <= pins_sync;
            if (puc_rise) begin
                // Power-up-clear restores defaults but leaves flags dead if the supervisor was off.
                ctrl_ff <= `WCM_CTRL_RST;
                supv_ff <= `WCM_SUPV_RST;
                div_ff <= `WCM_DIV_RST;
                sleep_lvl_ff <= 3'h0;
                irq_stat_ff <= {`WCM_IRQ_W{1'b0}};
                irq_mask_ff <= {`WCM_IRQ_W{1'b0}};
                flags_en_ff <= lse;
                state_ff <= ST_RUN;
                short_ff <= 1'b0;
                mask_cnt_ff <= {`WCM_CNT_W{1'b0}};
                ovs_cnt_ff <= {`WCM_CNT_W{1'b0}};
                fast_cnt_ff <= {`WCM_CNT_W{1'b0}};
            end else begin
                state_ff <= nxt_state;
                short_ff <= nxt_short;
                mask_cnt_ff <= nxt_mask_cnt;
                ovs_cnt_ff <= nxt_ovs_cnt;
                fast_cnt_ff <= nxt_fast_cnt;
                irq_stat_ff <= nxt_irq_stat;
                if (sleep_req && (state_ff == ST_RUN)) begin
                    sleep_lvl_ff <= HWDATA[2:0];
                end
                if (wr_en) begin
                    case (reg_addr)
                        `WCM_A_CTRL: begin
                            ctrl_ff <= {HWDATA[15:8], 3'h0, HWDATA[4:0]};
                        end
                        `WCM_A_SUPV: begin
                            supv_ff <= HWDATA[3:0];
                            flags_en_ff <= 1'b1;
                        end
                        `WCM_A_CLKDIV: begin
                            // Software halves the CPU clock here before sleeping and clears it later.
                            div_ff <= (HWDATA[2:0] > `WCM_DIV_MAX) ? `WCM_DIV_MAX : HWDATA[2:0];
                        end
                        `WCM_A_IRQ_MASK: begin
                            irq_mask_ff <= HWDATA[`WCM_IRQ_W-1:0];
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Clock enables and outputs
    // ------------------------------------------------------------------------
    // The CPU clock enable comes from a free divider; the mask gates it, the sub-clock never is.
    wire cpu_go = (nxt_state == ST_RUN) || puc_rise;
    wire [5:0] div_top = (6'h01 << div_ff) - 6'h01;

    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            div_cnt_ff <= 6'h00;
            CPU_RUN <= 1'b1;
            CPU_CLK_EN <= 1'b0;
            SUB_CLK_EN <= 1'b0;
            OSC_OVERSHOOT <= 1'b0;
            MAIN_CLK_FAST <= 1'b0;
            SUB_CLK_FAST <= 1'b0;
            IRQ <= 1'b0;
            HRESP <= 1'b0;
        end else begin
            div_cnt_ff <= (div_cnt_ff >= div_top) ? 6'h00 : div_cnt_ff + 6'h01;
            CPU_RUN <= cpu_go;
            CPU_CLK_EN <= cpu_go && (div_cnt_ff >= div_top);
            SUB_CLK_EN <= sub_alive;
            OSC_OVERSHOOT <= (nxt_ovs_cnt != {`WCM_CNT_W{1'b0}});
            MAIN_CLK_FAST <= (nxt_fast_cnt != {`WCM_CNT_W{1'b0}}) && (nxt_state == ST_RUN);
            // Only the second crystal keeps the sub-clock clear of the overshoot.
            SUB_CLK_FAST <= (nxt_ovs_cnt != {`WCM_CNT_W{1'b0}}) && sub_on_osc && sub_alive;
            IRQ <= |(nxt_irq_stat & irq_mask_ff);
            HRESP <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    always @* begin
        case (reg_addr)
            `WCM_A_CTRL: rd_data = {16'h0, ctrl_ff};
            `WCM_A_SUPV: rd_data = {28'h0, supv_ff};
            `WCM_A_CLKDIV: rd_data = {29'h0, div_ff};
            `WCM_A_SLEEP: rd_data = {29'h0, (state_ff == ST_SLEEP) ? sleep_lvl_ff : 3'h0};
            `WCM_A_STATUS: rd_data = {25'h0, short_cond, flags_en_ff, SUB_CLK_FAST, MAIN_CLK_FAST,
                OSC_OVERSHOOT, (state_ff == ST_MASK), (state_ff == ST_SLEEP)};
            `WCM_A_IRQ_STAT: rd_data = {28'h0, irq_stat_ff};
            `WCM_A_IRQ_MASK: rd_data = {28'h0, irq_mask_ff};
            default: rd_data = 32'h0;
        endcase
    end

endmodule
